// File: src/rcl_chan_select.sv
// Eligible channel count and lowest-first active channel pick
`timescale 1ns/1ps
module rcl_chan_select #(
  parameter int N = 64
) (
  input  wire logic [N-1:0] mask_i,
  input  wire logic [N-1:0] avail_i,
  input  wire logic [5:0]   min_i,
  output logic      [6:0]   count_o,
  output logic      [N-1:0] active_o
);
  always_comb begin
    logic [6:0] run;
    run      = 7'h00;
    active_o = '0;
    for (int i = 0; i < N; i++) begin
      if (mask_i[i] && avail_i[i]) begin
        active_o[i] = (run < {1'b0, min_i});
        run         = run + 7'h01;
      end
    end
    count_o = run;
  end
endmodule

// File: src/rcl_defines.svh
// Offsets, reset values and fixed codes of the radio channel link config block
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH
`define RCL_OFF_AVAIL_LO  12'h000
`define RCL_OFF_AVAIL_HI  12'h004
`define RCL_OFF_MASK_LO   12'h008
`define RCL_OFF_MASK_HI   12'h00C
`define RCL_OFF_MIN_CNT   12'h010
`define RCL_OFF_PREAMBLE  12'h014
`define RCL_OFF_NETWORK   12'h018
`define RCL_OFF_REPEAT    12'h01C
`define RCL_OFF_POWER     12'h020
`define RCL_OFF_RESEND    12'h024
`define RCL_OFF_SCAN      12'h028
`define RCL_OFF_PERSIST   12'h02C
`define RCL_MASK_RST      64'hFFFF_FFFF_FFF7_FFFF
`define RCL_MAP_ALL       64'hFFFF_FFFF_FFFF_FFFF
`define RCL_MAP_UPPER     64'hFFFF_FFFE_0000_0000
`define RCL_MAP_SPLIT     64'hFFFF_FFFE_0000_0FFF
`define RCL_MIN_STD       6'h19
`define RCL_MIN_SMALL     6'h0B
`define RCL_PRE_RST       3'h0
`define RCL_NET_RST       15'h7FFF
`define RCL_NET_FACTORY   16'hFFFF
`define RCL_REP_RST       3'h3
`define RCL_REP_MAX       3'h5
`define RCL_PWR_RST       3'h4
`define RCL_PWR_MAX       3'h4
`define RCL_RESEND_RST    4'hF
`define RCL_SCAN_RST      8'h10
`define RCL_ENERGY_FLOOR  8'hFF
`define RCL_CHAR_COMMA    8'h2C
`define RCL_CHAR_CR       8'h0D
`define RCL_MS_NS         1000000
`define RCL_CLK_NS        10
`endif

// File: src/rcl_pkg.sv
// Types shared by the radio channel link config block
package rcl_pkg;
  typedef enum logic [1:0] {
    RCL_REG_WIDE,
    RCL_REG_UPPER,
    RCL_REG_SPLIT,
    RCL_REG_SMALL
  } rcl_region_type;
  typedef enum logic [2:0] {
    RCL_IDLE,
    RCL_SCAN,
    RCL_VAL,
    RCL_COMMA,
    RCL_CR
  } rcl_scan_type;
  typedef struct packed {
    logic        valid;
    logic [2:0]  preamble;
    logic [14:0] network;
  } rcl_rx_type;
  typedef struct packed {
    logic [2:0]  bcast_sends;
    logic        ack_req;
    logic [3:0]  resend_limit;
    logic [2:0]  tx_power;
    logic [2:0]  preamble;
    logic [14:0] network;
  } rcl_cfg_type;
endpackage

// File: src/rcl_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
module rcl_tick #(
  parameter int DIV = 100000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      tick_o
);
  logic [31:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else begin
      tick_o  <= (cnt_reg == 32'(DIV - 1));
      cnt_reg <= (cnt_reg == 32'(DIV - 1)) ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
    end
  end
endmodule

// File: src/rcl_top.sv
// Radio channel link config: channels, rx filter, tx settings, energy scan
`timescale 1ns/1ps
`include "rcl_defines.svh"
module rcl_top #(
  parameter int          MS_CYCLES  = `RCL_MS_NS / `RCL_CLK_NS,
  parameter bit          OEM_NET_EN = 1'b1,
  parameter logic [14:0] FACTORY_NET = 15'h0A5C  // Arbitrary value
) (
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  input  wire logic               PSEL_I,
  input  wire logic               PENABLE_I,
  input  wire logic               PWRITE_I,
  input  wire logic [11:0]        PADDR_I,
  input  wire logic [31:0]        PWDATA_I,
  output logic      [31:0]        PRDATA_O,
  output logic                    PREADY_O,
  output logic                    PSLVERR_O,
  input  wire logic [1:0]         REGION_I,
  input  wire logic               NV_VALID_I,
  input  wire logic [14:0]        NV_NETWORK_I,
  output logic                    NV_SAVE_O,
  output logic      [14:0]        NV_DATA_O,
  input  wire rcl_pkg::rcl_rx_type RX_I,
  output logic                    RX_ACCEPT_O,
  output logic                    RX_DROP_PRE_O,
  output logic                    RX_DROP_NET_O,
  output logic      [63:0]        ACTIVE_MAP_O,
  output rcl_pkg::rcl_cfg_type    CFG_O,
  output logic                    SCAN_ON_O,
  output logic      [5:0]         SCAN_CH_O,
  input  wire logic               ENERGY_VALID_I,
  input  wire logic [7:0]         ENERGY_I,
  output logic                    RPT_VALID_O,
  output logic      [7:0]         RPT_BYTE_O,
  input  wire logic               RPT_READY_I
);
  rcl_pkg::rcl_region_type region_reg;
  rcl_pkg::rcl_scan_type   state_reg;
  logic        boot_reg;
  logic [63:0] mask_reg;
  logic [31:0] mask_lo_pend_reg;
  logic [2:0]  pre_reg;
  logic [14:0] net_reg;
  logic [2:0]  rep_reg;
  logic [2:0]  pwr_reg;
  logic [3:0]  resend_reg;
  logic [7:0]  scan_ms_reg;
  logic [7:0]  ms_left_reg;
  logic [5:0]  idx_reg;
  logic [7:0]  energy_mem [64];
  logic [63:0] avail;
  logic [5:0]  min_cnt;
  logic [6:0]  cand_cnt;
  logic [63:0] active_next;
  logic        ms_tick;
  logic        acc;
  logic        decide;
  logic        commit;
  logic        err_next;
  logic [31:0] rdata_next;
  // Region strap selects map and minimum count
  always_comb begin
    unique case (region_reg)
      rcl_pkg::RCL_REG_WIDE:  avail = `RCL_MAP_ALL;
      rcl_pkg::RCL_REG_UPPER: avail = `RCL_MAP_UPPER;
      rcl_pkg::RCL_REG_SPLIT: avail = `RCL_MAP_SPLIT;
      rcl_pkg::RCL_REG_SMALL: avail = `RCL_MAP_ALL;
    endcase
    min_cnt = (region_reg == rcl_pkg::RCL_REG_SMALL) ? `RCL_MIN_SMALL : `RCL_MIN_STD;
  end
  rcl_chan_select #(.N(64)) u_cand (
    .mask_i({PWDATA_I, mask_lo_pend_reg}), .avail_i(avail), .min_i(min_cnt), .count_o(cand_cnt), .active_o()
  );
  rcl_chan_select #(.N(64)) u_active (
    .mask_i(mask_reg), .avail_i(avail), .min_i(min_cnt), .count_o(), .active_o(active_next)
  );
  rcl_tick #(.DIV(MS_CYCLES)) u_tick (
    .clk_i(CLK_I), .rst_i(RST_I), .en_i(state_reg == rcl_pkg::RCL_SCAN), .tick_o(ms_tick)
  );
  // One wait state: decide in first access cycle, commit when ready is seen
  assign acc    = PSEL_I && PENABLE_I;
  assign decide = acc && !PREADY_O;
  assign commit = acc && PREADY_O && PWRITE_I && !PSLVERR_O;
  always_comb begin
    err_next   = 1'b0;
    rdata_next = 32'h0000_0000;
    unique case (PADDR_I)
      `RCL_OFF_AVAIL_LO: begin
        rdata_next = avail[31:0];
        err_next   = PWRITE_I;
      end
      `RCL_OFF_AVAIL_HI: begin
        rdata_next = avail[63:32];
        err_next   = PWRITE_I;
      end
      `RCL_OFF_MASK_LO: rdata_next = mask_reg[31:0];
      `RCL_OFF_MASK_HI: begin
        rdata_next = mask_reg[63:32];
        err_next   = PWRITE_I && (cand_cnt < {1'b0, min_cnt});
      end
      `RCL_OFF_MIN_CNT: begin
        rdata_next = {26'h000_0000, min_cnt};
        err_next   = PWRITE_I;
      end
      `RCL_OFF_PREAMBLE: begin
        rdata_next = {29'h0000_0000, pre_reg};
        err_next   = PWRITE_I && (PWDATA_I[31:3] != 29'h0000_0000);
      end
      `RCL_OFF_NETWORK: begin
        rdata_next = {17'h0_0000, net_reg};
        err_next   = PWRITE_I && !(PWDATA_I[31:15] == 17'h0_0000 ||
                     (OEM_NET_EN && PWDATA_I == {16'h0000, `RCL_NET_FACTORY}));
      end
      `RCL_OFF_REPEAT: begin
        rdata_next = {29'h0000_0000, rep_reg};
        err_next   = PWRITE_I && (PWDATA_I > {29'h0000_0000, `RCL_REP_MAX});
      end
      `RCL_OFF_POWER: begin
        rdata_next = {29'h0000_0000, pwr_reg};
        err_next   = PWRITE_I && (PWDATA_I > {29'h0000_0000, `RCL_PWR_MAX});
      end
      `RCL_OFF_RESEND: begin
        rdata_next = {28'h000_0000, resend_reg};
        err_next   = PWRITE_I && (PWDATA_I[31:4] != 28'h000_0000);
      end
      `RCL_OFF_SCAN: begin
        rdata_next = {23'h00_0000, state_reg != rcl_pkg::RCL_IDLE, scan_ms_reg};
        err_next   = PWRITE_I && (PWDATA_I[31:8] != 24'h00_0000 || state_reg != rcl_pkg::RCL_IDLE);
      end
      `RCL_OFF_PERSIST: rdata_next = 32'h0000_0000;
      default: err_next = 1'b1;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= decide;
      PSLVERR_O <= decide && err_next;
      PRDATA_O  <= (decide && !PWRITE_I) ? rdata_next : 32'h0000_0000;
    end
  end
  // Strap and stored network number caught one cycle after reset release
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      boot_reg   <= 1'b1;
      region_reg <= rcl_pkg::RCL_REG_WIDE;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        region_reg <= rcl_pkg::rcl_region_type'(REGION_I);
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mask_reg         <= `RCL_MASK_RST;
      mask_lo_pend_reg <= 32'h0000_0000;
      pre_reg          <= `RCL_PRE_RST;
      net_reg          <= `RCL_NET_RST;
      rep_reg          <= `RCL_REP_RST;
      pwr_reg          <= `RCL_PWR_RST;
      resend_reg       <= `RCL_RESEND_RST;
      NV_SAVE_O        <= 1'b0;
      NV_DATA_O        <= `RCL_NET_RST;
    end else begin
      NV_SAVE_O <= commit && (PADDR_I == `RCL_OFF_PERSIST);
      NV_DATA_O <= net_reg;
      if (boot_reg && NV_VALID_I) begin
        net_reg <= NV_NETWORK_I;
      end
      if (commit) begin
        unique case (PADDR_I)
          `RCL_OFF_MASK_LO:  mask_lo_pend_reg <= PWDATA_I;
          `RCL_OFF_MASK_HI:  mask_reg <= {PWDATA_I, mask_lo_pend_reg};
          `RCL_OFF_PREAMBLE: pre_reg <= PWDATA_I[2:0];
          `RCL_OFF_NETWORK:  net_reg <= PWDATA_I[15] ? FACTORY_NET : PWDATA_I[14:0];
          `RCL_OFF_REPEAT:   rep_reg <= PWDATA_I[2:0];
          `RCL_OFF_POWER:    pwr_reg <= PWDATA_I[2:0];
          `RCL_OFF_RESEND:   resend_reg <= PWDATA_I[3:0];
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ACTIVE_MAP_O <= 64'h0000_0000_0000_0000;
      CFG_O        <= '0;
    end else begin
      ACTIVE_MAP_O       <= active_next;
      CFG_O.bcast_sends  <= rep_reg + 3'h1;
      CFG_O.ack_req      <= (resend_reg != 4'h0);
      CFG_O.resend_limit <= resend_reg;
      CFG_O.tx_power     <= pwr_reg;
      CFG_O.preamble     <= pre_reg;
      CFG_O.network      <= net_reg;
    end
  end
  // Receive filter: preamble first, then network number
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RX_ACCEPT_O   <= 1'b0;
      RX_DROP_PRE_O <= 1'b0;
      RX_DROP_NET_O <= 1'b0;
    end else begin
      RX_DROP_PRE_O <= RX_I.valid && (RX_I.preamble != pre_reg);
      RX_DROP_NET_O <= RX_I.valid && (RX_I.preamble == pre_reg) && (RX_I.network != net_reg);
      RX_ACCEPT_O   <= RX_I.valid && (RX_I.preamble == pre_reg) && (RX_I.network == net_reg);
    end
  end
  // Energy scan and comma separated report
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg   <= rcl_pkg::RCL_IDLE;
      scan_ms_reg <= `RCL_SCAN_RST;
      ms_left_reg <= 8'h00;
      idx_reg     <= 6'h00;
      SCAN_ON_O   <= 1'b0;
      SCAN_CH_O   <= 6'h00;
      RPT_VALID_O <= 1'b0;
      RPT_BYTE_O  <= 8'h00;
    end else begin
      unique case (state_reg)
        rcl_pkg::RCL_IDLE: begin
          if (commit && PADDR_I == `RCL_OFF_SCAN) begin
            scan_ms_reg <= PWDATA_I[7:0];
            ms_left_reg <= PWDATA_I[7:0];
            SCAN_CH_O   <= 6'h00;
            idx_reg     <= 6'h00;
            for (int i = 0; i < 64; i++) begin
              energy_mem[i] <= `RCL_ENERGY_FLOOR;
            end
            SCAN_ON_O <= (PWDATA_I[7:0] != 8'h00);
            state_reg <= (PWDATA_I[7:0] != 8'h00) ? rcl_pkg::RCL_SCAN : rcl_pkg::RCL_VAL;
          end
        end
        rcl_pkg::RCL_SCAN: begin
          SCAN_CH_O <= SCAN_CH_O + 6'h01;
          if (ENERGY_VALID_I && ENERGY_I < energy_mem[SCAN_CH_O]) begin
            energy_mem[SCAN_CH_O] <= ENERGY_I;
          end
          if (ms_tick) begin
            ms_left_reg <= ms_left_reg - 8'h01;
            if (ms_left_reg == 8'h01) begin
              SCAN_ON_O <= 1'b0;
              state_reg <= rcl_pkg::RCL_VAL;
            end
          end
        end
        rcl_pkg::RCL_VAL: begin
          RPT_VALID_O <= 1'b1;
          RPT_BYTE_O  <= energy_mem[idx_reg];
          if (RPT_VALID_O && RPT_READY_I) begin
            RPT_BYTE_O <= `RCL_CHAR_COMMA;
            state_reg  <= rcl_pkg::RCL_COMMA;
          end
        end
        rcl_pkg::RCL_COMMA: begin
          if (RPT_READY_I) begin
            idx_reg    <= idx_reg + 6'h01;
            RPT_VALID_O <= (idx_reg == 6'h3F);
            RPT_BYTE_O <= `RCL_CHAR_CR;
            state_reg  <= (idx_reg == 6'h3F) ? rcl_pkg::RCL_CR : rcl_pkg::RCL_VAL;
          end
        end
        rcl_pkg::RCL_CR: begin
          if (RPT_READY_I) begin
            RPT_VALID_O <= 1'b0;
            state_reg   <= rcl_pkg::RCL_IDLE;
          end
        end
        default: state_reg <= rcl_pkg::RCL_IDLE;
      endcase
    end
  end
  sequence s_decide_write(logic [11:0] a);
    decide && PWRITE_I && PADDR_I == a;
  endsequence
  AST_RO_WRITE: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_decide_write(`RCL_OFF_MIN_CNT) |=> PSLVERR_O && PREADY_O ##1 $stable(min_cnt))
    else $error("read-only write not refused");
  AST_MASK_REJECT: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_decide_write(`RCL_OFF_MASK_HI) ##0 (cand_cnt < {1'b0, min_cnt}) |=> PSLVERR_O ##1 $stable(mask_reg))
    else $error("short channel mask accepted");
  AST_MASK_RST: assert property (@(posedge CLK_I) disable iff (RST_I)
    boot_reg |-> mask_reg == `RCL_MASK_RST)
    else $error("mask reset value wrong");
  AST_ACTIVE_SUBSET: assert property (@(posedge CLK_I) disable iff (RST_I)
    !boot_reg |=> (ACTIVE_MAP_O & ~$past(mask_reg & avail)) == 64'h0000_0000_0000_0000)
    else $error("inactive channel in active map");
  AST_ACTIVE_COUNT: assert property (@(posedge CLK_I) disable iff (RST_I)
    1'b1 |=> $countones(ACTIVE_MAP_O) <= $past(min_cnt))
    else $error("more channels active than minimum");
  AST_PRE_FIRST: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX_I.valid && RX_I.preamble != pre_reg |=> RX_DROP_PRE_O && !RX_DROP_NET_O && !RX_ACCEPT_O)
    else $error("preamble not checked first");
  AST_NET_MATCH: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX_I.valid && RX_I.preamble == pre_reg && RX_I.network == net_reg |=> RX_ACCEPT_O)
    else $error("matching packet dropped");
  AST_FACTORY: assert property (@(posedge CLK_I) disable iff (RST_I)
    commit && PADDR_I == `RCL_OFF_NETWORK && PWDATA_I[15:0] == `RCL_NET_FACTORY |=> net_reg == FACTORY_NET)
    else $error("factory network number not used");
  AST_BCAST: assert property (@(posedge CLK_I) disable iff (RST_I)
    !boot_reg |=> CFG_O.bcast_sends == $past(rep_reg) + 3'h1)
    else $error("broadcast send count wrong");
  AST_ACK: assert property (@(posedge CLK_I) disable iff (RST_I)
    !boot_reg |=> CFG_O.ack_req == ($past(resend_reg) != 4'h0))
    else $error("ack request does not follow resend limit");
  AST_REPORT_END: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_reg == rcl_pkg::RCL_COMMA && idx_reg == 6'h3F && RPT_READY_I |=> RPT_VALID_O && RPT_BYTE_O == `RCL_CHAR_CR)
    else $error("report does not end in carriage return");
endmodule

// File: verif/rcl_radio_model.sv
// Model of the radio front end and the scan report sink
`timescale 1ns/1ps
module rcl_radio_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 scan_on_i,
  input  wire logic [5:0]           scan_ch_i,
  input  wire logic                 rpt_valid_i,
  input  wire logic [7:0]           rpt_byte_i,
  output rcl_pkg::rcl_rx_type       rx_o,
  output logic                      energy_valid_o,
  output logic      [7:0]           energy_o,
  output logic                      rpt_ready_o
);
  logic [7:0] rpt_q[$];
  logic       ready_reg;
  initial begin
    rx_o      = '0;
    ready_reg = 1'b0;
  end
  // Energy tracks the channel under scan, scrambled outside a scan
  assign energy_valid_o = scan_on_i;
  assign energy_o       = scan_on_i ? {2'b01, scan_ch_i} : {2'b10, ~scan_ch_i};
  assign rpt_ready_o    = ready_reg;
  // Sink stalls every other cycle
  always @(posedge clk_i) begin
    ready_reg <= rst_i ? 1'b0 : ~ready_reg;
    if (rpt_valid_i === 1'b1 && rpt_ready_o === 1'b1) begin
      rpt_q.push_back(rpt_byte_i);
    end
  end
  task automatic send(input logic [2:0] pre, input logic [14:0] net);
    @(posedge clk_i);
    rx_o <= {1'b1, pre, net};
    @(posedge clk_i);
    rx_o <= {1'b0, ~pre, ~net};
  endtask
endmodule

// File: verif/tb_radio_channel_link_config.sv
// Self-checking bench for the radio channel link config block
`timescale 1ns/1ps
module tb_radio_channel_link_config;
  localparam int          MS   = 20;
  localparam logic [14:0] FNET = 15'h0A5C;  // Arbitrary value
  logic                 clk, rst, psel, penable, pwrite, pready, pslverr, nv_valid, nv_save;
  logic                 rx_acc, rx_pre, rx_net, scan_on, e_valid, rpt_valid, rpt_ready;
  logic [1:0]           region;
  logic [5:0]           scan_ch;
  logic [7:0]           energy, rpt_byte;
  logic [11:0]          paddr;
  logic [14:0]          nv_net, nv_data;
  logic [31:0]          pwdata, prdata;
  logic [63:0]          active_map;
  rcl_pkg::rcl_rx_type  rx;
  rcl_pkg::rcl_cfg_type cfg;
  int                   err_total, comparisons, saves, scan_cycles;
  logic [31:0] lo_t[4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0FFF, 32'hFFFF_FFFF};
  logic [31:0] hi_t[4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFE, 32'hFFFF_FFFF};
  logic [11:0] ra[9]   = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h024, 12'h028};
  logic [31:0] rv[9]   = '{32'hFFFF_FFFF, 32'hFFF7_FFFF, 32'hFFFF_FFFF, 32'h0000_0019, 32'h0000_0000,
                           32'h0000_0003, 32'h0000_0004, 32'h0000_000F, 32'h0000_0010};
  logic [11:0] ea[9]   = '{12'h000, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h018, 12'h030};
  logic [31:0] ed[9]   = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0008, 32'h0000_0006, 32'h0000_0005,
                           32'h0000_0010, 32'h0000_0100, 32'h0000_8000, 32'h0000_0000};
  logic [2:0]  rx_exp;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  rcl_top #(.MS_CYCLES(MS), .FACTORY_NET(FNET)) dut (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .REGION_I(region), .NV_VALID_I(nv_valid), .NV_NETWORK_I(nv_net), .NV_SAVE_O(nv_save),
    .NV_DATA_O(nv_data), .RX_I(rx), .RX_ACCEPT_O(rx_acc), .RX_DROP_PRE_O(rx_pre),
    .RX_DROP_NET_O(rx_net), .ACTIVE_MAP_O(active_map), .CFG_O(cfg), .SCAN_ON_O(scan_on),
    .SCAN_CH_O(scan_ch), .ENERGY_VALID_I(e_valid), .ENERGY_I(energy), .RPT_VALID_O(rpt_valid),
    .RPT_BYTE_O(rpt_byte), .RPT_READY_I(rpt_ready)
  );

  rcl_radio_model radio (
    .clk_i(clk), .rst_i(rst), .scan_on_i(scan_on), .scan_ch_i(scan_ch), .rpt_valid_i(rpt_valid),
    .rpt_byte_i(rpt_byte), .rx_o(rx), .energy_valid_o(e_valid), .energy_o(energy),
    .rpt_ready_o(rpt_ready)
  );

  always @(posedge clk) begin
    if (nv_save === 1'b1) saves++;
    if (scan_on === 1'b1) scan_cycles++;
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk($sformatf("wr err %h", a), e, ee);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk($sformatf("rd %h", a), r, exp);
  endtask

  task automatic do_reset(input logic [1:0] rg, input logic nvv, input logic [14:0] nvn);
    @(posedge clk);
    rst      <= 1'b1;
    region   <= rg;
    nv_valid <= nvv;
    nv_net   <= nvn;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic defaults;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    test_done;
  end

  initial begin
    {rst, psel, penable, pwrite, nv_valid} = 5'b10000;
    {region, paddr, pwdata, nv_net} = '0;
    for (int g = 3; g >= 0; g--) begin
      do_reset(2'(g), g == 2, 15'h0321);
      rd(12'h000, lo_t[g]);
      rd(12'h004, hi_t[g]);
      rd(12'h010, (g == 3) ? 32'h0000_000B : 32'h0000_0019);
      rd(12'h018, (g == 2) ? 32'h0000_0321 : 32'h0000_7FFF);
    end
    $display("test regions done");
    defaults;
    chk("cfg", cfg, {3'h4, 1'b1, 4'hF, 3'h4, 3'h0, 15'h7FFF});
    chk("active", active_map, 64'h0000_0000_03F7_FFFF);
    for (int i = 0; i < 9; i++) wr(ea[i], ed[i], 1'b1);
    defaults;
    $display("test refusals done");
    wr(12'h008, 32'h00FF_FFFF, 1'b0);
    wr(12'h00C, 32'h0000_0000, 1'b1);
    rd(12'h008, 32'hFFF7_FFFF);
    wr(12'h008, 32'h01FF_FFFF, 1'b0);
    wr(12'h00C, 32'h0000_0000, 1'b0);
    repeat (2) @(posedge clk);
    chk("active", active_map, 64'h0000_0000_01FF_FFFF);
    $display("test mask done");
    for (int p = 0; p < 5; p++) begin
      wr(12'h020, p, 1'b0);
      repeat (2) @(posedge clk);
      chk("power", cfg.tx_power, p);
    end
    for (int p = 0; p < 6; p++) begin
      wr(12'h01C, p, 1'b0);
      repeat (2) @(posedge clk);
      chk("sends", cfg.bcast_sends, p + 1);
    end
    for (int p = 0; p < 2; p++) begin
      wr(12'h024, p, 1'b0);
      repeat (2) @(posedge clk);
      chk("ack", {cfg.ack_req, cfg.resend_limit}, {p == 1, 4'(p)});
    end
    $display("test tx settings done");
    wr(12'h014, 32'h0000_0005, 1'b0);
    wr(12'h018, 32'h0000_1234, 1'b0);
    for (int k = 0; k < 4; k++) begin
      radio.send(k[1] ? 3'h4 : 3'h5, k[0] ? 15'h1235 : 15'h1234);
      @(posedge clk);
      rx_exp = (k == 0) ? 3'b100 : (k == 1) ? 3'b001 : 3'b010;
      chk("rx", {rx_acc, rx_pre, rx_net}, rx_exp);
    end
    $display("test rx filter done");
    wr(12'h018, 32'h0000_FFFF, 1'b0);
    rd(12'h018, {17'h0_0000, FNET});
    saves = 0;
    wr(12'h02C, 32'h0000_0000, 1'b0);
    repeat (2) @(posedge clk);
    chk("saves", saves, 1);
    chk("nv data", nv_data, FNET);
    $display("test network done");
    radio.rpt_q.delete();
    scan_cycles = 0;
    wr(12'h028, 32'h0000_0004, 1'b0);
    wr(12'h028, 32'h0000_0002, 1'b1);
    rd(12'h028, 32'h0000_0104);
    for (int n = 0; n < 3000 && radio.rpt_q.size() < 129; n++) @(posedge clk);
    chk("scan len", scan_cycles == 4 * MS || scan_cycles == 4 * MS + 1, 1);
    chk("rpt count", radio.rpt_q.size(), 129);
    for (int ch = 0; ch < 64; ch++) begin
      chk("energy", radio.rpt_q[2 * ch], 64'h40 + ch);
      chk("comma", radio.rpt_q[2 * ch + 1], 64'h2C);
    end
    chk("cr", radio.rpt_q[128], 64'h0D);
    radio.rpt_q.delete();
    scan_cycles = 0;
    wr(12'h028, 32'h0000_0000, 1'b0);
    for (int n = 0; n < 3000 && radio.rpt_q.size() < 129; n++) @(posedge clk);
    chk("zero scan len", scan_cycles, 0);
    chk("zero rpt count", radio.rpt_q.size(), 129);
    chk("zero energy", radio.rpt_q[126], 64'hFF);
    chk("zero comma", radio.rpt_q[127], 64'h2C);
    chk("zero cr", radio.rpt_q[128], 64'h0D);
    $display("test scan done");
    test_done;
  end
endmodule
